/* File: core/safe_torque_off_monitor.sv */
`timescale 1ns/100ps

// Function
// - With both channels high the block is ready and drives torque per run.
// - Ch1 only high is ch2 fault, ch2 only high is ch1 fault, none cutoff.
// - Both channels low stops output whatever the run command says.
// - A dual-channel fault mode is entered when both internal checks fail.
// - An open stop loop stops output and, unless a hardware-fault mode is held, raises the cutoff display flag.
// - With latch setting 0 the cutoff alarm holds until a reset command.
// - With latch setting 1 the cutoff alarm clears when its cause is gone.
// - All hardware-fault modes latch until reset, whatever the latch setting.
// - With restart option 1 a still-held run resumes at once after reset.
// - Select 66 makes the safety output open with no alarm, closed in any alarm mode.
// - Select 68 makes the safety output closed with no alarm, open in any alarm mode.
// - Entering cutoff logs code 76 in the fault history.
// - Ch1 fault logs 72, ch2 fault 77, dual fault 78.
// - The history holds six codes, newest first.
// - Mismatched board, card and firmware is flagged and blocks running.
module safe_torque_off_monitor #(
	parameter int DEPTH = sto_monitor_pkg::HIST_DEPTH
) (
	input  wire logic                        ref_clk,    // 50 MHz clock
	input  wire logic                        rst_n,      // Async reset
	input  wire logic                        enableChannelOneInput, // Pin
	input  wire logic                        enableChannelTwoInput, // Pin
	input  wire logic                        ch1CheckFail, // Internal test
	input  wire logic                        ch2CheckFail, // Internal test
	input  wire logic                        runCmd,     // Run/stop
	input  wire logic                        resetCmd,   // Alarm reset
	input  wire sto_monitor_pkg::stoConfig_t cfg,        // Settings
	input  wire sto_monitor_pkg::hwCombo_t   combo,      // Board/card/fw
	output logic                             torqueEnable, // Drive output
	output logic                             cutoffDisplay, // Keypad flag
	output logic                             safetyRelay, // 1 = closed
	output logic                             comboError, // Mismatch
	output sto_monitor_pkg::stoState_t       stoState,   // Present mode
	output logic [DEPTH-1:0][7:0]            faultHistory // [0] newest
);

	logic              rstSync1_r;
	logic              rstSync_r;
	logic              rstN;
	logic [1:0]        chSync;
	logic [1:0]        chkSync;
	logic              ch1;
	logic              ch2;
	logic              cutoffAlarm_r;
	logic              hwFault_r;
	sto_monitor_pkg::stoState_t liveState;
	sto_monitor_pkg::stoState_t state_r;
	logic              alarmActive;
	logic              runPrev_r;
	logic              runArmed_r;
	logic              newEntry;
	logic [7:0]        newCode;
	logic              isReady;

	// ==========================================================
	// Reset release
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1_r <= 1'b0;
			rstSync_r  <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstSync_r  <= rstSync1_r;
		end
	end
	assign rstN = rstSync_r;

	// ==========================================================
	// Pin synchronisers; inputs idle low so reset reads as cutoff
	sto_input_sync #(.WIDTH(2), .RESET_VAL(1'b0)) uChSync (
		.clk     (ref_clk),
		.rstN    (rstN),
		.asyncIn ({enableChannelTwoInput, enableChannelOneInput}),
		.syncOut (chSync)
	);
	assign ch1 = chSync[0];
	assign ch2 = chSync[1];
	assign chkSync = {ch2CheckFail, ch1CheckFail}; // Same-clock checks

	// ==========================================================
	// Channel decode, dual internal fault dominates
	always_comb begin
		if (chkSync[0] && chkSync[1]) begin
			liveState = sto_monitor_pkg::ST_DUALFLT;
		end else if (chkSync[0]) begin
			liveState = sto_monitor_pkg::ST_CH1FAULT;
		end else if (chkSync[1]) begin
			liveState = sto_monitor_pkg::ST_CH2FAULT;
		end else begin
			unique case ({ch2, ch1})
				2'h3: liveState = sto_monitor_pkg::ST_READY;
				2'h1: liveState = sto_monitor_pkg::ST_CH2FAULT;
				2'h2: liveState = sto_monitor_pkg::ST_CH1FAULT;
				2'h0: liveState = sto_monitor_pkg::ST_CUTOFF;
			endcase
		end
	end

	// ==========================================================
	// Held mode: faults latch, cutoff latches per setting
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			state_r <= sto_monitor_pkg::ST_CUTOFF;
		end else if (liveState != sto_monitor_pkg::ST_READY) begin
			// Hardware faults outrank a held cutoff; new cause wins reset
			if (!hwFault_r || liveState != sto_monitor_pkg::ST_CUTOFF) begin
				state_r <= liveState;
			end
		end else if (hwFault_r) begin
			if (resetCmd) begin
				state_r <= sto_monitor_pkg::ST_READY;
			end
		end else if (cutoffAlarm_r) begin
			if (resetCmd ||
			    cfg.alarmLatchSetting == sto_monitor_pkg::LATCH_OFF) begin
				state_r <= sto_monitor_pkg::ST_READY;
			end
		end
	end

	assign hwFault_r     = state_r != sto_monitor_pkg::ST_READY &&
	                       state_r != sto_monitor_pkg::ST_CUTOFF;
	assign cutoffAlarm_r = state_r == sto_monitor_pkg::ST_CUTOFF;
	assign alarmActive   = state_r != sto_monitor_pkg::ST_READY;
	assign stoState      = state_r;
	assign isReady       = !alarmActive && !comboError;

	// ==========================================================
	// Run arming: after any alarm, a fresh run edge is needed unless
	// restart is enabled; this stops a stuck run line from restarting.
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			runPrev_r  <= 1'b0;
			runArmed_r <= 1'b0;
		end else begin
			runPrev_r <= runCmd;
			if (alarmActive) begin
				runArmed_r <= cfg.restartAfterResetOption ==
				              sto_monitor_pkg::RESTART_ON;
			end else if (runCmd && !runPrev_r) begin
				runArmed_r <= 1'b1;
			end
		end
	end

	// Torque output and indications
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			torqueEnable  <= 1'b0;
			cutoffDisplay <= 1'b0;
			safetyRelay   <= 1'b0;
		end else begin
			// Live decode gates too, so a cut bites before the latch
			torqueEnable <= isReady && runCmd && runArmed_r &&
			                liveState == sto_monitor_pkg::ST_READY;
			cutoffDisplay <= cutoffAlarm_r;
			unique case (cfg.multiFunctionOutputSelect)
				sto_monitor_pkg::MFO_SAFE_NO: safetyRelay <= alarmActive;
				sto_monitor_pkg::MFO_SAFE_NC: safetyRelay <= !alarmActive;
				default:                      safetyRelay <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Board, card and firmware check
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			comboError <= 1'b0;
		end else begin
			comboError <= !((!combo.newBoard && !combo.newCard) ||
			               (combo.newBoard && combo.newCard &&
			                combo.newFirmware));
		end
	end

	// ==========================================================
	// Fault history: log on entering a new alarm mode
	always_comb begin
		newEntry = liveState != sto_monitor_pkg::ST_READY &&
		           liveState != state_r &&
		           !(hwFault_r && liveState == sto_monitor_pkg::ST_CUTOFF);
		unique case (liveState)
			sto_monitor_pkg::ST_CUTOFF:   newCode = sto_monitor_pkg::CODE_CUTOFF;
			sto_monitor_pkg::ST_CH1FAULT: newCode = sto_monitor_pkg::CODE_CH1;
			sto_monitor_pkg::ST_CH2FAULT: newCode = sto_monitor_pkg::CODE_CH2;
			sto_monitor_pkg::ST_DUALFLT:  newCode = sto_monitor_pkg::CODE_DUAL;
			default:                      newCode = sto_monitor_pkg::CODE_NONE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			faultHistory <= '0;
		end else if (newEntry) begin
			faultHistory <= {faultHistory[DEPTH-2:0], newCode};
		end
	end

	// ==========================================================
	// Checks
	property p_cutoffStops;
		@(posedge ref_clk) disable iff (!rstN)
		(liveState == sto_monitor_pkg::ST_CUTOFF) |=> !torqueEnable;
	endproperty
	a_cutoffStops: assert property (p_cutoffStops) else $error("torque on in cutoff");

	property p_readyRuns;
		@(posedge ref_clk) disable iff (!rstN)
		(isReady && runCmd && runArmed_r &&
		 liveState == sto_monitor_pkg::ST_READY) |=> torqueEnable;
	endproperty
	a_readyRuns: assert property (p_readyRuns) else $error("ready run not driven");

	property p_decode;
		@(posedge ref_clk) disable iff (!rstN)
		(!chkSync[0] && !chkSync[1] && ch1 && !ch2) |->
		liveState == sto_monitor_pkg::ST_CH2FAULT;
	endproperty
	a_decode: assert property (p_decode) else $error("bad channel decode");

	property p_dual;
		@(posedge ref_clk) disable iff (!rstN)
		(chkSync == 2'h3) |=> state_r == sto_monitor_pkg::ST_DUALFLT;
	endproperty
	a_dual: assert property (p_dual) else $error("dual fault missed");

	property p_latch;
		@(posedge ref_clk) disable iff (!rstN)
		(cutoffAlarm_r && !resetCmd &&
		 cfg.alarmLatchSetting == sto_monitor_pkg::LATCH_ON)
		|=> cutoffAlarm_r;
	endproperty
	a_latch: assert property (p_latch) else $error("cutoff alarm dropped");

	property p_noLatch;
		@(posedge ref_clk) disable iff (!rstN)
		(cutoffAlarm_r &&
		 cfg.alarmLatchSetting == sto_monitor_pkg::LATCH_OFF &&
		 liveState == sto_monitor_pkg::ST_READY) |=> !alarmActive;
	endproperty
	a_noLatch: assert property (p_noLatch) else $error("no self clear");

	property p_hwLatch;
		@(posedge ref_clk) disable iff (!rstN)
		(hwFault_r && !resetCmd) |=> hwFault_r;
	endproperty
	a_hwLatch: assert property (p_hwLatch) else $error("fault dropped");

	property p_relayNo;
		@(posedge ref_clk) disable iff (!rstN)
		(cfg.multiFunctionOutputSelect == sto_monitor_pkg::MFO_SAFE_NO) ##1
		(cfg.multiFunctionOutputSelect == sto_monitor_pkg::MFO_SAFE_NO) |->
		safetyRelay == $past(alarmActive);
	endproperty
	a_relayNo: assert property (p_relayNo) else $error("relay state wrong");

	property p_logCutoff;
		@(posedge ref_clk) disable iff (!rstN)
		(newEntry && liveState == sto_monitor_pkg::ST_CUTOFF) |=>
		faultHistory[0] == sto_monitor_pkg::CODE_CUTOFF;
	endproperty
	a_logCutoff: assert property (p_logCutoff) else $error("code not logged");

	c_cutoff: cover property (@(posedge ref_clk) disable iff (!rstN)
		cutoffAlarm_r ##1 !alarmActive);
	c_dual:   cover property (@(posedge ref_clk) disable iff (!rstN)
		state_r == sto_monitor_pkg::ST_DUALFLT);
	c_run:    cover property (@(posedge ref_clk) disable iff (!rstN)
		torqueEnable);

endmodule

/* File: core/sto_input_sync.sv */
`timescale 1ns/100ps

// Three-stage synchroniser; a change is taken once stages two and three
// agree, so a single-cycle glitch on stage two never reaches the output.
module sto_input_sync #(
	parameter int   WIDTH = 2,
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic             clk,      // Core clock
	input  wire logic             rstN,     // Synchronised reset
	input  wire logic [WIDTH-1:0] asyncIn,  // Raw pins
	output logic      [WIDTH-1:0] syncOut   // Filtered level
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;

	// ==========================================================
	// Synchroniser chain
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta_r   <= {WIDTH{RESET_VAL}};
			stage2_r <= {WIDTH{RESET_VAL}};
			stage3_r <= {WIDTH{RESET_VAL}};
		end else begin
			meta_r   <= asyncIn;
			stage2_r <= meta_r;
			stage3_r <= stage2_r;
		end
	end

	// Per-bit agreement filter
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					syncOut[i] <= RESET_VAL;
				end else if (stage2_r[i] == stage3_r[i]) begin
					syncOut[i] <= stage3_r[i];
				end
			end
		end
	endgenerate

endmodule

/* File: core/sto_monitor_pkg.sv */
package sto_monitor_pkg;

	// ==========================================================
	// Channel decode and states
	typedef enum logic [4:0] {
		ST_READY    = 5'h01,
		ST_CUTOFF   = 5'h02,
		ST_CH1FAULT = 5'h04,
		ST_CH2FAULT = 5'h08,
		ST_DUALFLT  = 5'h10
	} stoState_t;

	// ==========================================================
	// Fault codes written into the history
	localparam logic [7:0] CODE_NONE    = 8'h00;
	localparam logic [7:0] CODE_CH1     = 8'h48; // 72
	localparam logic [7:0] CODE_CUTOFF  = 8'h4C; // 76
	localparam logic [7:0] CODE_CH2     = 8'h4D; // 77
	localparam logic [7:0] CODE_DUAL    = 8'h4E; // 78
	localparam int         HIST_DEPTH   = 6;

	// ==========================================================
	// Settings
	localparam logic       LATCH_ON        = 1'b0;
	localparam logic       LATCH_OFF       = 1'b1;
	localparam logic       RESTART_ON      = 1'b1;
	localparam logic [7:0] MFO_SAFE_NO     = 8'h42; // 66
	localparam logic [7:0] MFO_SAFE_NC     = 8'h44; // 68
	localparam logic       ALARM_LATCH_RST = 1'b0;
	localparam logic       RESTART_RST     = 1'b0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic alarmLatchSetting;      // 0 latch, 1 self-clear
		logic restartAfterResetOption; // 1 resume on reset
		logic [7:0] multiFunctionOutputSelect;
	} stoConfig_t;

	typedef struct packed {
		logic newBoard;
		logic newCard;
		logic newFirmware;
	} hwCombo_t;

endpackage

/* File: verification/emergency_stop_switch_loop.sv */
`timescale 1ns/100ps

// ==========================================================
// Emergency-stop loop wired to both enable channels
module emergency_stop_switch_loop (
	input  wire logic estopOpen, // Switch pressed
	input  wire logic cutOne,    // Broken wire, channel one
	input  wire logic cutTwo,    // Broken wire, channel two
	output logic      chOnePin,  // Channel one level
	output logic      chTwoPin   // Channel two level
);
	// Opening the switch drops both channels in the same instant; a cut
	// wire drops only one, which is how a one-channel fault is staged
	assign chOnePin = !estopOpen && !cutOne;
	assign chTwoPin = !estopOpen && !cutTwo;
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps

module tb;
	// ==========================================================
	// Stimulus and observed signals
	logic                        ref_clk = 1'b0;
	logic                        rst_n;
	logic                        estopOpen = 1'b0;
	logic                        cutOne = 1'b0;
	logic                        cutTwo = 1'b0;
	logic                        chk1 = 1'b0;
	logic                        chk2 = 1'b0;
	logic                        runCmd = 1'b0;
	logic                        resetCmd = 1'b0;
	sto_monitor_pkg::stoConfig_t cfg = 10'h044;
	sto_monitor_pkg::hwCombo_t   combo = 3'h0;
	logic                        pin1, pin2, torque, disp, relay, cErr;
	sto_monitor_pkg::stoState_t  state;
	logic [5:0][7:0]             hist;
	logic [7:0]                  expHist [6];
	int                          failures = 0;
	int                          samples_checked = 0;
	int                          cycles = 0;

	always #10 ref_clk = ~ref_clk;

	emergency_stop_switch_loop loop (.estopOpen(estopOpen), .cutOne(cutOne),
		.cutTwo(cutTwo), .chOnePin(pin1), .chTwoPin(pin2));

	safe_torque_off_monitor uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.enableChannelOneInput(pin1), .enableChannelTwoInput(pin2),
		.ch1CheckFail(chk1), .ch2CheckFail(chk2), .runCmd(runCmd),
		.resetCmd(resetCmd), .cfg(cfg), .combo(combo),
		.torqueEnable(torque), .cutoffDisplay(disp), .safetyRelay(relay),
		.comboError(cErr), .stoState(state), .faultHistory(hist));

	// ==========================================================
	// Shared helpers; inputs always change 1 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Newest code enters slot 0 and the oldest falls off slot 5
	task automatic log_check(input logic [7:0] code);
		for (int i = 5; i > 0; i--) expHist[i] = expHist[i-1];
		expHist[0] = code;
		for (int i = 0; i < 6; i++) check("history", hist[i], expHist[i]);
	endtask

	task automatic pulse_reset();
		resetCmd = 1'b1;
		cyc(1);
		resetCmd = 1'b0;
		cyc(3);
	endtask

	// Restart option off needs a fresh run edge before output returns
	task automatic rerun();
		runCmd = 1'b0;
		cyc(2);
		runCmd = 1'b1;
		cyc(3);
		check("torque", 8'(torque), 8'h01);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_ready();
		cyc(8);
		check("state", 8'(state), 8'(sto_monitor_pkg::ST_CUTOFF));
		pulse_reset();
		check("state", 8'(state), 8'(sto_monitor_pkg::ST_READY));
		rerun();
		check("torque", 8'(torque), 8'h01);
		runCmd = 1'b0;
		cyc(3);
		check("torque", 8'(torque), 8'h00);
		runCmd = 1'b1;
		cyc(3);
		check("relay", 8'(relay), 8'h01);
		cfg.multiFunctionOutputSelect = sto_monitor_pkg::MFO_SAFE_NO;
		cyc(3);
		check("relay", 8'(relay), 8'h00);
		cfg.multiFunctionOutputSelect = sto_monitor_pkg::MFO_SAFE_NC;
		cyc(3);
	endtask

	task automatic t_cutoff(input logic latch, input logic restart);
		cfg.alarmLatchSetting = latch;
		cfg.restartAfterResetOption = restart;
		estopOpen = 1'b1;
		cyc(8);
		check("state", 8'(state), 8'(sto_monitor_pkg::ST_CUTOFF));
		check("torque", 8'(torque), 8'h00);
		check("display", 8'(disp), 8'h01);
		check("relay", 8'(relay), 8'h00);
		log_check(sto_monitor_pkg::CODE_CUTOFF);
		estopOpen = 1'b0;
		cyc(8);
		if (latch) begin
			check("state", 8'(state), 8'(sto_monitor_pkg::ST_READY));
			check("display", 8'(disp), 8'h00);
			cyc(2);
		end else begin
			check("state", 8'(state), 8'(sto_monitor_pkg::ST_CUTOFF));
			check("display", 8'(disp), 8'h01);
			pulse_reset();
		end
		check("torque", 8'(torque), 8'(restart));
		if (!restart) rerun();
	endtask

	// Hardware faults latch even with the self-clearing setting chosen
	task automatic t_hw(input logic c1, input logic c2, input logic ck,
		input sto_monitor_pkg::stoState_t st, input logic [7:0] code);
		cfg.alarmLatchSetting = 1'b1;
		cfg.restartAfterResetOption = 1'b0;
		cfg.multiFunctionOutputSelect = sto_monitor_pkg::MFO_SAFE_NO;
		cutOne = c1;
		cutTwo = c2;
		chk1 = ck;
		chk2 = ck;
		cyc(8);
		check("state", 8'(state), 8'(st));
		check("torque", 8'(torque), 8'h00);
		check("relay", 8'(relay), 8'h01);
		log_check(code);
		{cutOne, cutTwo, chk1, chk2} = 4'h0;
		cyc(8);
		check("state", 8'(state), 8'(st));
		pulse_reset();
		check("state", 8'(state), 8'(sto_monitor_pkg::ST_READY));
		cfg.multiFunctionOutputSelect = sto_monitor_pkg::MFO_SAFE_NC;
		rerun();
	endtask

	// Only old board with old card, or all three new, may run
	task automatic t_combo();
		for (int i = 0; i < 8; i++) begin
			combo = 3'(i);
			cyc(3);
			check("combo", 8'(cErr), 8'(!(i < 2 || i == 7)));
			if (!(i < 2 || i == 7)) check("torque", 8'(torque), 8'h00);
		end
	endtask

	// ==========================================================
	// Verdict and hang guard
	task automatic stop_test();
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles >= 3000) begin
			failures++;
			stop_test();
		end
	end

	initial begin
		// A falling edge at time zero clears the flops before any clock
		rst_n = 1'b0;
		for (int i = 0; i < 6; i++) expHist[i] = 8'h00;
		cyc(12);
		rst_n = 1'b1;
		t_ready();
		t_cutoff(1'b0, 1'b0);
		t_cutoff(1'b0, 1'b1);
		t_cutoff(1'b1, 1'b0);
		t_hw(1'b0, 1'b1, 1'b0, sto_monitor_pkg::ST_CH2FAULT,
			sto_monitor_pkg::CODE_CH2);
		t_hw(1'b1, 1'b0, 1'b0, sto_monitor_pkg::ST_CH1FAULT,
			sto_monitor_pkg::CODE_CH1);
		t_hw(1'b0, 1'b0, 1'b1, sto_monitor_pkg::ST_DUALFLT,
			sto_monitor_pkg::CODE_DUAL);
		// Seventh entry pushes the oldest code out of slot 5
		t_cutoff(1'b1, 1'b1);
		t_combo();
		stop_test();
	end
endmodule
